// *** hdl/asts_core.sv ***
// Purpose: sample-time settings for channels 4..7 and sequencer feedback
// Assumes: converter clock rides on sys_clk (conversion steps are sys_clk cycles)
// Notes: one Wishbone slave, ack or err one cycle after request, no wait states
//
// Overview of operation
// - four 8-bit sample-time fields, ch7 topmost
// - sample phase lasts two plus field cycles
// - current channel readable at bits 18:16
// - active sequence readable at bits 13:11
// - bit 10 high during exceptional sequence
// - bit 9 high during exceptional interrupt
// - bit 8 runs sequencer, reads run state
`timescale 1ns/1ps
module asts_core
  import asts_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  // sequencer side
  input wire logic seqAdvance, // pulse: sequencer steps to new conversion
  input wire logic [2:0] nextChannel, // channel of the new conversion
  input wire logic [2:0] nextSequence, // sequence of the new conversion
  input wire logic excSeqBusyIn, // exceptional sequence measurement running
  input wire logic excIntBusyIn, // exceptional interrupt measurement running
  input wire logic seqStopped, // sequencer reports it actually halted
  // sample phase
  input wire logic sampleStart, // pulse: begin sampling current channel
  output logic sampleActive, // high during sample phase
  output logic sampleDone, // pulse: sample phase ended
  output logic postprocRun // run request to the sequencer
);

  // ****************************************************************
  // register state
  // ****************************************************************
  logic [31:0] sampleTime_r, sampleTime_nxt; // extra sample cycles
  logic run_r, run_nxt; // postproc_run control
  logic [2:0] chan_r, chan_nxt; // current_channel
  logic [2:0] seq_r, seq_nxt; // current_sequence
  logic excSeq_r, excSeq_nxt; // exc_sequence_busy
  logic excInt_r, excInt_nxt; // exc_interrupt_busy
  logic ack_r, ack_nxt; // bus ack
  logic err_r, err_nxt; // bus error for unmapped address
  logic [31:0] rdat_r, rdat_nxt; // read data
  logic req; // new request, not yet answered
  logic hitSt, hitFb; // address decode

  // byte-lane merge used on the sample-time word
  function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++)
      if (sel[i])
        res[i*8 +: 8] = wd[i*8 +: 8];
    return res;
  endfunction

  // feedback word built from live state, reserved bits zero
  // a read shows the sequencer as it stood in the cycle the request was taken
  function automatic logic [31:0] fbWord(input logic [2:0] c, input logic [2:0] s,
                                          input logic es, input logic ei, input logic rn);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[ASTS_CHAN_LSB +: 3] = c;
    w[ASTS_SEQ_LSB +: 3] = s;
    w[ASTS_EXC_SEQ_BIT] = es;
    w[ASTS_EXC_INT_BIT] = ei;
    w[ASTS_RUN_BIT] = rn;
    return w;
  endfunction

  // ack and err are registered, so a request still held high in the answer
  // cycle must not be taken twice; the answer flags mask it for that cycle
  assign req = wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  // only the low address byte is decoded; aliasing above it is left to the
  // bus fabric in front of this block
  assign hitSt = (wb_adr_i == ASTS_OFF_SAMPLE_TIME);
  assign hitFb = (wb_adr_i == ASTS_OFF_SEQ_FB);

  // ****************************************************************
  // bus and status next state
  // ****************************************************************
  // one access per request; the answer comes the cycle after it is seen
  always_comb
  begin
    sampleTime_nxt = sampleTime_r;
    run_nxt = run_r;
    chan_nxt = chan_r;
    seq_nxt = seq_r;
    excSeq_nxt = excSeqBusyIn;
    excInt_nxt = excIntBusyIn;
    ack_nxt = 1'b0;
    err_nxt = 1'b0;
    rdat_nxt = rdat_r;
    // status follows the sequencer step by step
    if (seqAdvance)
    begin
      chan_nxt = nextChannel;
      seq_nxt = nextSequence;
    end
    // a halt reported by the sequencer clears the run bit so reads show truth
    if (seqStopped)
      run_nxt = 1'b0;
    if (req)
    begin
      // reads return the word as it stood before any write of this cycle
      if (hitSt || hitFb)
        ack_nxt = 1'b1;
      else
        err_nxt = 1'b1; // unmapped: error, no side effect
      if (wb_we_i && hitSt)
        sampleTime_nxt = laneMerge(sampleTime_r, wb_dat_i, wb_sel_i);
      // software write wins over a halt in the same cycle, it is newer intent
      if (wb_we_i && hitFb && wb_sel_i[1])
        run_nxt = wb_dat_i[ASTS_RUN_BIT];
      if (hitSt)
        rdat_nxt = sampleTime_r;
      else if (hitFb)
        rdat_nxt = fbWord(chan_r, seq_r, excSeq_r, excInt_r, run_r);
      else
        rdat_nxt = 32'h0000_0000;
    end
  end

  // bus and status registers only; every decision is made above
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sampleTime_r <= ASTS_SAMPLE_TIME_RST;
      run_r <= 1'b0;
      chan_r <= 3'h0;
      seq_r <= 3'h0;
      excSeq_r <= 1'b0;
      excInt_r <= 1'b0;
      ack_r <= 1'b0;
      err_r <= 1'b0;
      rdat_r <= 32'h0000_0000;
    end
    else
    begin
      sampleTime_r <= sampleTime_nxt;
      run_r <= run_nxt;
      chan_r <= chan_nxt;
      seq_r <= seq_nxt;
      excSeq_r <= excSeq_nxt;
      excInt_r <= excInt_nxt;
      ack_r <= ack_nxt;
      err_r <= err_nxt;
      rdat_r <= rdat_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_err_o = err_r;
  assign wb_dat_o = rdat_r;
  assign postprocRun = run_r;

  // ****************************************************************
  // sample phase timer
  // ****************************************************************
  asts_state_t state_r, state_nxt; // sample phase state
  logic [8:0] cnt_r, cnt_nxt; // sample cycles left after the current one
  logic done_r, done_nxt; // end-of-phase pulse
  logic [7:0] extra; // field of the current channel

  // one step here is one converter clock, since that clock is taken as sys_clk;
  // a slower converter clock would need its own stepping logic
  // the field is picked when the phase starts, so a rewrite during a phase
  // only takes effect at the next start
  // channels 0..3 have no field here; they get the bare minimum phase
  always_comb
  begin
    extra = 8'h00;
    if (chan_r[2])
      extra = sampleTime_r[chan_r[1:0]*8 +: 8];
  end

  // counts 2 + field cycles from the start pulse
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    case (state_r)
      ASTS_IDLE:
      begin
        if (sampleStart)
        begin
          state_nxt = ASTS_SAMPLE;
          cnt_nxt = ASTS_MIN_SAMPLE_CYC + {1'b0, extra} - 9'h001;
        end
      end
      ASTS_SAMPLE:
      begin
        if (cnt_r == 9'h000)
        begin
          state_nxt = ASTS_IDLE;
          done_nxt = 1'b1;
        end
        else
          cnt_nxt = cnt_r - 9'h001;
      end
      default:
        state_nxt = ASTS_IDLE;
    endcase
  end

  // timer registers only
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_r <= ASTS_IDLE;
      cnt_r <= 9'h000;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  // active is decoded from the state register alone, so it never glitches
  assign sampleActive = (state_r == ASTS_SAMPLE);
  assign sampleDone = done_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  // every check watches inputs, registers, outputs and internal decodes of this block; reset turns
  // them off so the asynchronous clear is never judged as a rule breach
  // run bit follows a software write, even against a halt in the same cycle
  AST_RUN_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req && wb_we_i && hitFb && wb_sel_i[1]) |=> (postprocRun == $past(wb_dat_i[ASTS_RUN_BIT])))
    else $error("run bit did not follow write");
  AST_RUN_STOP: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (seqStopped && !(req && wb_we_i && hitFb)) |=> !postprocRun)
    else $error("run bit not cleared on halt");
  AST_CHAN_ADV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    seqAdvance ##1 (wb_cyc_i && wb_stb_i && hitFb && !ack_r && !err_r && !seqAdvance)
      |=> (wb_dat_o[18:16] == $past(nextChannel, 2)))
    else $error("channel field wrong");
  AST_SEQ_ADV: assert property (@(posedge sys_clk) disable iff (!rst_b)
    seqAdvance |=> (seq_r == $past(nextSequence)))
    else $error("sequence field wrong");
  AST_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !seqAdvance |=> $stable(chan_r) && $stable(seq_r))
    else $error("status changed without advance");
  AST_EXC_SEQ: assert property (@(posedge sys_clk) disable iff (!rst_b)
    excSeqBusyIn |=> excSeq_r)
    else $error("exc sequence flag missing");
  AST_EXC_INT: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !excIntBusyIn |=> !excInt_r)
    else $error("exc interrupt flag stuck");
  AST_MIN_PHASE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ASTS_IDLE && sampleStart) |=> sampleActive [*2])
    else $error("sample phase shorter than two");
  AST_PHASE_LEN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ASTS_IDLE && sampleStart && extra == 8'h00) |=> ##2 sampleDone)
    else $error("minimum phase length wrong");
  AST_ST_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req && wb_we_i && hitSt && wb_sel_i == 4'hf) |=> (sampleTime_r == $past(wb_dat_i)))
    else $error("sample time write lost");
  AST_ACK_ONE: assert property (@(posedge sys_clk) disable iff (!rst_b)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than a cycle");
  // an unmapped address is answered with err and never with ack
  AST_ERR_UNMAPPED: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (req && !hitSt && !hitFb) |=> (wb_err_o && !wb_ack_o))
    else $error("unmapped access not refused");
  // ack and err never stand together
  AST_ACK_EXCL: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  // the end pulse comes right after the last sample cycle
  AST_DONE_AFTER: assert property (@(posedge sys_clk) disable iff (!rst_b)
    $fell(sampleActive) |-> sampleDone)
    else $error("sample end pulse missing");
  // channels without a field here get exactly the minimum phase
  AST_LOW_CHAN: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (state_r == ASTS_IDLE && sampleStart && !chan_r[2]) |=> sampleActive ##1 sampleActive ##1 sampleDone)
    else $error("low channel phase length wrong");

  // cover points for the main scenarios
  COV_RUN: cover property (@(posedge sys_clk) disable iff (!rst_b) $rose(postprocRun));
  COV_PHASE: cover property (@(posedge sys_clk) disable iff (!rst_b) sampleDone && chan_r[2]);
  COV_ERR: cover property (@(posedge sys_clk) disable iff (!rst_b) wb_err_o);
  COV_ADV: cover property (@(posedge sys_clk) disable iff (!rst_b) seqAdvance ##1 seqAdvance);
  COV_LOW_CHAN: cover property (@(posedge sys_clk) disable iff (!rst_b) sampleDone && !chan_r[2]);

endmodule

// *** hdl/asts_pkg.sv ***
// Purpose: constants for the converter sample-time and sequencer status block
// Assumes: classic Wishbone slave, 32-bit data, byte addresses
// Notes: all offsets and fields, and the sample-time reset value, live here
package asts_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] ASTS_OFF_SAMPLE_TIME = 8'h2c; // extra sample cycles ch4..7
  localparam logic [7:0] ASTS_OFF_SEQ_FB = 8'h50; // sequencer feedback
  localparam logic [31:0] ASTS_SAMPLE_TIME_RST = 32'h0000_0000;
  // ****************************************************************
  // feedback fields
  // ****************************************************************
  localparam int ASTS_CHAN_LSB = 16; // current_channel 18:16
  localparam int ASTS_SEQ_LSB = 11; // current_sequence 13:11
  localparam int ASTS_EXC_SEQ_BIT = 10; // exc_sequence_busy
  localparam int ASTS_EXC_INT_BIT = 9; // exc_interrupt_busy
  localparam int ASTS_RUN_BIT = 8; // postproc_run
  // ****************************************************************
  // sample phase timing
  // ****************************************************************
  localparam logic [8:0] ASTS_MIN_SAMPLE_CYC = 9'h002; // minimum sample phase
  // state of one sample phase
  typedef enum logic [1:0] {ASTS_IDLE, ASTS_SAMPLE} asts_state_t;
endpackage

// *** tb/asts_core_tb_top.sv ***
// Purpose: self-checking bench for the sample-time and sequencer feedback block
// Assumes: 200 MHz sys_clk, Wishbone ack or err one cycle after a request
// Notes: the bench drives every block input itself, no partner model
`timescale 1ns/1ps
module asts_core_tb_top
  import asts_pkg::*;
();
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic sys_clk = 1'b0; // 5 ns period
  logic rst_b = 1'b0; // async reset, active low
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0; // bus request
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'h0;
  logic [31:0] wbDatW = 32'h0, wbDatR; // write and read data
  logic wbAck, wbErr;
  logic seqAdvance = 1'b0, excSeqBusyIn = 1'b0, excIntBusyIn = 1'b0, seqStopped = 1'b0;
  logic [2:0] nextChannel = 3'h0, nextSequence = 3'h0;
  logic sampleStart = 1'b0, sampleActive, sampleDone, postprocRun;
  int bad_count = 0; // mismatches
  int n_tests = 0; // comparisons made
  logic [31:0] rdVal; // last read data
  logic rdErr; // last error flag
  int cnt; // sample phase length seen
  always #2.5 sys_clk = ~sys_clk;
  asts_core dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
    .wb_err_o(wbErr), .seqAdvance(seqAdvance), .nextChannel(nextChannel), .nextSequence(nextSequence),
    .excSeqBusyIn(excSeqBusyIn), .excIntBusyIn(excIntBusyIn), .seqStopped(seqStopped),
    .sampleStart(sampleStart), .sampleActive(sampleActive), .sampleDone(sampleDone),
    .postprocRun(postprocRun));
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  // compare and count; four-state equality so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic cycle; entered just after a rising edge, request held until ack or err
  task automatic wb(input logic we, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
    int n;
    n = 0;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbSel <= s;
    wbDatW <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end
    while (wbAck !== 1'b1 && wbErr !== 1'b1 && n < 50);
    if (n >= 50) bad_count++; // slave never answered
    rdVal = wbDatR;
    rdErr = wbErr;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
    @(posedge sys_clk); // idle cycle between requests
  endtask
  // expected feedback word from its fields
  function automatic logic [31:0] fb(input logic [2:0] ch, input logic [2:0] sq, input logic es,
    input logic ei, input logic rn);
    return {13'h0, ch, 2'b00, sq, es, ei, rn, 8'h00};
  endfunction
  // sequencer steps to a new channel and sequence; returns right after the
  // advancing edge, so a following read or start is taken one edge later
  // and the read lands in the cycle the channel check watches
  task automatic adv(input logic [2:0] ch, input logic [2:0] sq);
    seqAdvance <= 1'b1;
    nextChannel <= ch;
    nextSequence <= sq;
    @(posedge sys_clk);
    seqAdvance <= 1'b0;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  // reset values, unmapped address refused with zero data
  task automatic t_reset_unmapped();
    wb(1'b0, ASTS_OFF_SAMPLE_TIME, 4'hf, 32'h0);
    chk("st reset", rdVal, 32'h0);
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb reset", rdVal, 32'h0);
    wb(1'b1, 8'h30, 4'hf, 32'hffff_ffff);
    chk("unmapped err", {31'h0, rdErr}, 32'h1);
    wb(1'b0, 8'h30, 4'hf, 32'h0);
    chk("unmapped data", rdVal, 32'h0);
  endtask
  // four independent byte fields, ch7 in the top byte, byte-lane writes
  task automatic t_fields();
    wb(1'b1, ASTS_OFF_SAMPLE_TIME, 4'hf, 32'h1122_3344);
    wb(1'b0, ASTS_OFF_SAMPLE_TIME, 4'hf, 32'h0);
    chk("st full", rdVal, 32'h1122_3344);
    wb(1'b1, ASTS_OFF_SAMPLE_TIME, 4'b0100, 32'hffaa_ffff);
    wb(1'b0, ASTS_OFF_SAMPLE_TIME, 4'hf, 32'h0);
    chk("st ch6 lane", rdVal, 32'h11aa_3344);
  endtask
  // every channel and sequence code reaches the feedback fields
  task automatic t_status();
    for (int i = 0; i < 8; i++)
    begin
      adv(i[2:0], 3'(7 - i));
      wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
      chk("fb chan seq", rdVal, fb(i[2:0], 3'(7 - i), 1'b0, 1'b0, 1'b0));
    end
    excSeqBusyIn <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb exc seq", rdVal, fb(3'h7, 3'h0, 1'b1, 1'b0, 1'b0));
    excSeqBusyIn <= 1'b0;
    excIntBusyIn <= 1'b1;
    @(posedge sys_clk);
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb exc int", rdVal, fb(3'h7, 3'h0, 1'b0, 1'b1, 1'b0));
    excIntBusyIn <= 1'b0;
    @(posedge sys_clk);
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb idle", rdVal, fb(3'h7, 3'h0, 1'b0, 1'b0, 1'b0));
  endtask
  // run bit: only bit 8 is writable, actual stop clears it
  task automatic t_run();
    wb(1'b1, ASTS_OFF_SEQ_FB, 4'hf, 32'hffff_ffff);
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb run", rdVal, fb(3'h7, 3'h0, 1'b0, 1'b0, 1'b1));
    chk("run out", {31'h0, postprocRun}, 32'h1);
    seqStopped <= 1'b1;
    @(posedge sys_clk);
    seqStopped <= 1'b0;
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb stopped", rdVal, 32'h0007_0000);
    chk("run out stop", {31'h0, postprocRun}, 32'h0);
    // a run write and a halt taken at the same edge: the write wins
    fork
      wb(1'b1, ASTS_OFF_SEQ_FB, 4'h2, 32'h0000_0100);
      begin
        seqStopped <= 1'b1;
        @(posedge sys_clk);
        seqStopped <= 1'b0;
      end
    join
    wb(1'b0, ASTS_OFF_SEQ_FB, 4'hf, 32'h0);
    chk("fb write wins", rdVal, fb(3'h7, 3'h0, 1'b0, 1'b0, 1'b1));
  endtask
  // sample phase lasts two plus the field of the current channel
  task automatic t_sample();
    logic [2:0] chs [4] = '{3'h5, 3'h7, 3'h4, 3'h2};
    int exps [4] = '{2 + 5, 2 + 10, 2 + 0, 2};
    wb(1'b1, ASTS_OFF_SAMPLE_TIME, 4'hf, 32'h0a03_0500);
    foreach (chs[k])
    begin
      adv(chs[k], 3'h1);
      sampleStart <= 1'b1;
      @(posedge sys_clk);
      sampleStart <= 1'b0;
      cnt = 0;
      for (int n = 0; n < 300; n++)
      begin
        @(posedge sys_clk);
        if (sampleDone === 1'b1) break;
        if (sampleActive === 1'b1) cnt++;
      end
      chk("sample len", 32'(cnt), 32'(exps[k]));
      @(posedge sys_clk);
    end
  endtask
  // ****************************************************************
  // sequence, watchdog and verdict
  // ****************************************************************
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // the whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    close_out();
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset_unmapped();
    t_fields();
    t_status();
    t_run();
    t_sample();
    close_out();
  end
endmodule
